//--- src/mxp_status_timing.v
`timescale 1ns/1ps
`include "mxp_defs.vh"
// control, timing fallback, laser shutdown and indicators of the muxponder
module mxp_status_timing #(
    parameter SEC_CYCLES = `CLK_HZ
) (
    input wire sys_clk,
    input wire resetn,
    // apb slave
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    output reg irq,
    // client and trunk byte streams
    input wire [31:0] clientTxData,
    output reg [7:0] trunkTxData,
    input wire [7:0] trunkRxData,
    output reg [31:0] clientRxData,
    output reg trunkRateSel,
    // timing sources
    input wire shelfClkAOk,
    input wire shelfClkBOk,
    output reg txClockSel,
    output reg clockAlarm,
    // port alarms, bits 3:0 clients, bit 4 trunk
    input wire [4:0] lossOfSignal,
    input wire [4:0] lossOfFrame,
    input wire [4:0] highBer,
    input wire fiberMiswire,
    // lasers
    output reg [3:0] clientLaserOn,
    output reg trunkLaserOn,
    // indicators
    output reg failLed,
    output reg actLedGreen,
    output reg actLedAmber,
    output reg signalFailLed,
    output reg [3:0] clientLed,
    output reg trunkLed,
    output reg wave1Led,
    output reg wave2Led
);
    // =====================================================
    // trunk shutdown states
    // =====================================================
    localparam ST_RUN = 2'd0;   // laser on, link good
    localparam ST_OFF = 2'd1;   // laser off, waiting off phase
    localparam ST_PULSE = 2'd2; // restart pulse, laser on

    // =====================================================
    // declarations
    // =====================================================
    reg [`CTRL_W-1:0] ctrl;      // software control bits
    reg [`IRQ_W-1:0] irqStat;    // sticky events
    reg [`IRQ_W-1:0] irqMask;    // enables onto irq
    reg [15:0] alsOnSec;         // restart pulse on time
    reg [15:0] alsOffSec;        // off time between pulses
    reg [31:0] preCount;         // cycles toward one second
    reg secTick;                 // one-cycle pulse per second
    reg flash;                   // boot flash phase
    reg [1:0] alsState;
    reg [1:0] next_alsState;
    reg [15:0] alsSec;           // seconds spent in phase
    reg [1:0] slot;              // client lane in trunk
    reg onFallback;
    reg sfPrev;
    wire [4:0] losS;
    wire [4:0] lofS;
    wire [4:0] berS;
    wire [2:0] miscS;
    wire apbWrite;
    wire apbSetup;
    wire [`IRQ_W-1:0] irqEvent;
    wire [`IRQ_W-1:0] irqClear;
    wire [4:0] portOk;
    wire sigFail;
    wire operational;
    wire anyActive;
    wire [15:0] onLimit;
    wire [15:0] offLimit;
    wire [3:0] clientInSvc;

    // =====================================================
    // input synchronisers
    // =====================================================
    // alarm pins come from optics on other clocks
    sync_bits #(.W(15)) u_alarmSync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .din({highBer, lossOfFrame, lossOfSignal}),
        .dout({berS, lofS, losS})
    );
    sync_bits #(.W(3)) u_miscSync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        // clock-good pins enter inverted so the reset state reads as not lost
        .din({fiberMiswire, ~shelfClkBOk, ~shelfClkAOk}),
        .dout(miscS)
    );

    // =====================================================
    // derived conditions
    // =====================================================
    assign clientInSvc = ctrl[`CTRL_CLIENT_INSVC_HI:`CTRL_CLIENT_INSVC_LO];
    // a port receives a recognized signal with no loss or frame alarm
    assign portOk = ~(losS | lofS);
    // any port failure or a miswire lights signal fail
    assign sigFail = (|(losS | lofS | berS)) | miscS[2];
    assign operational = ctrl[`CTRL_CPU_READY] & ~ctrl[`CTRL_BOOTING];
    assign anyActive = |({ctrl[`CTRL_TRUNK_INSVC], clientInSvc} & portOk);
    // short programmed phases are stretched past sixty seconds
    assign onLimit = (alsOnSec < `ALS_MIN_SEC) ? `ALS_MIN_SEC : alsOnSec;
    assign offLimit = (alsOffSec < `ALS_MIN_SEC) ? `ALS_MIN_SEC : alsOffSec;

    // =====================================================
    // apb decode
    // =====================================================
    assign apbSetup = psel & ~penable;
    assign apbWrite = psel & penable & pready & pwrite;
    assign irqClear = (apbWrite && paddr == `OFF_IRQ_STAT) ? pwdata[`IRQ_W-1:0]
                                                          : {`IRQ_W{1'b0}};

    // ready and read data are prepared in the setup cycle,
    // so every access ends after exactly one access cycle
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (apbSetup) begin
            pready <= 1'b1;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
            case (paddr)
                `OFF_CTRL: begin
                    prdata <= {21'h000000, ctrl};
                end
                `OFF_STATUS: begin
                    prdata <= {11'h000, losS, lofS, berS,
                               miscS[2], signalFailLed, trunkLaserOn,
                               alsState, clockAlarm};
                end
                `OFF_IRQ_STAT: begin
                    prdata <= {29'h00000000, irqStat};
                end
                `OFF_IRQ_MASK: begin
                    prdata <= {29'h00000000, irqMask};
                end
                `OFF_ALS_ON: begin
                    prdata <= {16'h0000, alsOnSec};
                end
                `OFF_ALS_OFF: begin
                    prdata <= {16'h0000, alsOffSec};
                end
                default: begin
                    // unmapped address answers with an error
                    pslverr <= 1'b1;
                end
            endcase
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
    end

    // =====================================================
    // control registers
    // =====================================================
    // written only on the completing access cycle
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            ctrl <= `CTRL_RESET;
            irqMask <= {`IRQ_W{1'b0}};
            alsOnSec <= `ALS_ON_RESET;
            alsOffSec <= `ALS_OFF_RESET;
        end else if (apbWrite) begin
            case (paddr)
                `OFF_CTRL: begin
                    ctrl <= pwdata[`CTRL_W-1:0];
                end
                `OFF_IRQ_MASK: begin
                    irqMask <= pwdata[`IRQ_W-1:0];
                end
                `OFF_ALS_ON: begin
                    alsOnSec <= pwdata[15:0];
                end
                `OFF_ALS_OFF: begin
                    alsOffSec <= pwdata[15:0];
                end
                default: begin
                    // read-only or unmapped: nothing stored
                end
            endcase
        end
    end

    // =====================================================
    // interrupts
    // =====================================================
    assign irqEvent[`IRQ_FALLBACK] = ~onFallback & miscS[0] & miscS[1];
    assign irqEvent[`IRQ_SIGFAIL] = sigFail & ~sfPrev;
    assign irqEvent[`IRQ_SHUTDOWN] = (alsState == ST_RUN) && (next_alsState == ST_OFF);

    // a new event wins over a write-one clear in the same cycle
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            irqStat <= {`IRQ_W{1'b0}};
            sfPrev <= 1'b0;
            irq <= 1'b0;
        end else begin
            irqStat <= (irqStat & ~irqClear) | irqEvent;
            sfPrev <= sigFail;
            irq <= |(((irqStat & ~irqClear) | irqEvent) & irqMask);
        end
    end

    // =====================================================
    // timing source selection
    // =====================================================
    // the change of source is not hitless; traffic may take errors
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            onFallback <= 1'b0;
            txClockSel <= 1'b0;
            clockAlarm <= 1'b0;
            trunkRateSel <= 1'b0;
        end else begin
            onFallback <= miscS[0] & miscS[1];
            // 0 selects shelf timing, 1 the internal fallback clock
            txClockSel <= miscS[0] & miscS[1];
            clockAlarm <= miscS[0] & miscS[1];
            // 0 native line rate, 1 wrapped rate with fec
            trunkRateSel <= ctrl[`CTRL_WRAP];
        end
    end

    // =====================================================
    // mux and demux of client lanes
    // =====================================================
    // lanes interleave byte by byte; lane order fixed by slot
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            slot <= 2'd0;
            trunkTxData <= 8'h00;
            clientRxData <= 32'h00000000;
        end else begin
            slot <= slot + 2'd1;
            case (slot)
                2'd0: begin
                    trunkTxData <= clientTxData[7:0];
                    clientRxData[7:0] <= trunkRxData;
                end
                2'd1: begin
                    trunkTxData <= clientTxData[15:8];
                    clientRxData[15:8] <= trunkRxData;
                end
                2'd2: begin
                    trunkTxData <= clientTxData[23:16];
                    clientRxData[23:16] <= trunkRxData;
                end
                default: begin
                    trunkTxData <= clientTxData[31:24];
                    clientRxData[31:24] <= trunkRxData;
                end
            endcase
        end
    end

    // =====================================================
    // seconds prescaler
    // =====================================================
    // whole seconds keep long phases in a 16-bit count
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            preCount <= 32'h00000000;
            secTick <= 1'b0;
            flash <= 1'b0;
        end else if (preCount == SEC_CYCLES - 1) begin
            preCount <= 32'h00000000;
            secTick <= 1'b1;
            flash <= ~flash;
        end else begin
            preCount <= preCount + 32'h00000001;
            secTick <= 1'b0;
        end
    end

    // =====================================================
    // trunk laser shutdown
    // =====================================================
    // off on loss; then a restart pulse each off phase until signal returns
    always @* begin
        next_alsState = alsState;
        case (alsState)
            ST_RUN: begin
                if (ctrl[`CTRL_ALS_EN] && losS[4]) begin
                    next_alsState = ST_OFF;
                end
            end
            ST_OFF: begin
                if (!ctrl[`CTRL_ALS_EN]) begin
                    next_alsState = ST_RUN;
                end else if (secTick && alsSec + 16'd1 >= offLimit) begin
                    next_alsState = ST_PULSE;
                end
            end
            ST_PULSE: begin
                if (!ctrl[`CTRL_ALS_EN] || !losS[4]) begin
                    next_alsState = ST_RUN;
                end else if (secTick && alsSec + 16'd1 >= onLimit) begin
                    next_alsState = ST_OFF;
                end
            end
            default: begin
                next_alsState = ST_RUN;
            end
        endcase
    end

    // phase seconds restart on every state change
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            alsState <= ST_RUN;
            alsSec <= 16'h0000;
            trunkLaserOn <= 1'b1;
            clientLaserOn <= 4'hf;
        end else begin
            alsState <= next_alsState;
            if (next_alsState != alsState) begin
                alsSec <= 16'h0000;
            end else if (secTick) begin
                alsSec <= alsSec + 16'd1;
            end
            trunkLaserOn <= (next_alsState != ST_OFF);
            // client lasers follow their own receive loss
            clientLaserOn <= ctrl[`CTRL_ALS_EN] ? ~losS[3:0] : 4'hf;
        end
    end

    // =====================================================
    // indicators
    // =====================================================
    // reset drives fail on; all led outputs are flops
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            failLed <= 1'b1;
            actLedGreen <= 1'b0;
            actLedAmber <= 1'b0;
            signalFailLed <= 1'b0;
            clientLed <= 4'h0;
            trunkLed <= 1'b0;
            wave1Led <= 1'b0;
            wave2Led <= 1'b0;
        end else begin
            if (ctrl[`CTRL_BOOTING]) begin
                failLed <= flash;
            end else begin
                failLed <= ~ctrl[`CTRL_CPU_READY];
            end
            actLedGreen <= operational & ~ctrl[`CTRL_STANDBY] & anyActive;
            actLedAmber <= operational & ctrl[`CTRL_STANDBY];
            signalFailLed <= sigFail;
            clientLed <= clientInSvc & portOk[3:0];
            trunkLed <= ctrl[`CTRL_TRUNK_INSVC] & portOk[4];
            wave1Led <= ~ctrl[`CTRL_WAVE2];
            wave2Led <= ctrl[`CTRL_WAVE2];
        end
    end
endmodule

//--- src/mxp_defs.vh
`ifndef MXP_DEFS_VH
`define MXP_DEFS_VH

// =====================================================
// register byte offsets
// =====================================================
`define OFF_CTRL 8'h00
`define OFF_STATUS 8'h04
`define OFF_IRQ_STAT 8'h08
`define OFF_IRQ_MASK 8'h0c
`define OFF_ALS_ON 8'h10
`define OFF_ALS_OFF 8'h14

// =====================================================
// control register fields
// =====================================================
`define CTRL_WRAP 0
`define CTRL_STANDBY 1
`define CTRL_CPU_READY 2
`define CTRL_BOOTING 3
`define CTRL_WAVE2 4
`define CTRL_TRUNK_INSVC 5
`define CTRL_CLIENT_INSVC_LO 6
`define CTRL_CLIENT_INSVC_HI 9
`define CTRL_ALS_EN 10
`define CTRL_W 11
`define CTRL_RESET 11'h000

// =====================================================
// interrupt status fields
// =====================================================
`define IRQ_FALLBACK 0
`define IRQ_SIGFAIL 1
`define IRQ_SHUTDOWN 2
`define IRQ_W 3

// =====================================================
// trunk rates in kbit/s, one for each trunkRateSel setting
// =====================================================
`define RATE_NATIVE_KBPS 32'd9953280
`define RATE_WRAPPED_KBPS 32'd10709230

// =====================================================
// timing
// =====================================================
`define CLK_HZ 100000000
// least trunk pulse phase, in seconds; phases must exceed 60 s
`define ALS_MIN_SEC 16'd61
`define ALS_ON_RESET 16'h003d
`define ALS_OFF_RESET 16'h003d

`endif

//--- src/sync_bits.v
`timescale 1ns/1ps
// two flip-flop synchroniser, one stage pair per bit
module sync_bits #(
    parameter W = 1
) (
    input wire sys_clk,
    input wire resetn,
    input wire [W-1:0] din,
    output wire [W-1:0] dout
);
    // =====================================================
    // per-bit stages
    // =====================================================
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg meta; // first stage, read only by the second
            reg held; // second stage, safe to use
            always @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    meta <= 1'b0;
                    held <= 1'b0;
                end else begin
                    meta <= din[i];
                    held <= meta;
                end
            end
            assign dout[i] = held;
        end
    endgenerate
endmodule

//--- bench/mxp_status_timing_sva.sv
`timescale 1ns/1ps
// ==========================================
// port checker for the status and timing block
module mxp_status_timing_sva (
    input wire sys_clk,
    input wire resetn,
    input wire psel,
    input wire penable,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [31:0] clientTxData,
    input wire [7:0] trunkTxData,
    input wire shelfClkAOk,
    input wire shelfClkBOk,
    input wire txClockSel,
    input wire clockAlarm,
    input wire [4:0] lossOfSignal,
    input wire [4:0] lossOfFrame,
    input wire [4:0] highBer,
    input wire fiberMiswire,
    input wire actLedGreen,
    input wire actLedAmber,
    input wire signalFailLed,
    input wire wave1Led,
    input wire wave2Led
);
    reg [2:0] upCnt; // edges since reset, saturating; keeps $past clear of reset
    reg [1:0] slot; // our own copy of the lane pointer
    reg [7:0] expTx; // lane byte the trunk should show in this same cycle
    wire bothLost = !shelfClkAOk && !shelfClkBOk;
    wire anyFault = |{lossOfSignal, lossOfFrame, highBer, fiberMiswire};
    // ==========================================
    // helper logic
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            upCnt <= 3'h0;
            slot <= 2'h0;
            expTx <= 8'h00;
        end else begin
            // stop at seven so the guard never wraps
            if (upCnt != 3'h7) begin
                upCnt <= upCnt + 3'h1;
            end
            slot <= slot + 2'h1;
            expTx <= clientTxData[8*slot +: 8];
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    // ==========================================
    // assertions
    a_ready_after_setup: assert property (psel && !penable |=> pready)
        else $error("no ready after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_error_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error without ready or with data");
    a_fallback_select: assert property (upCnt > 3 |-> txClockSel == $past(bothLost, 3))
        else $error("clock source does not follow shelf clocks");
    a_alarm_tracks: assert property (clockAlarm == txClockSel)
        else $error("clock alarm differs from fallback");
    a_sigfail_follow: assert property (upCnt > 3 |-> signalFailLed == $past(anyFault, 3))
        else $error("signal fail led wrong");
    a_wave_one_lit: assert property (upCnt > 3 |-> wave1Led != wave2Led)
        else $error("wavelength leds not one lit");
    a_act_exclusive: assert property (!(actLedGreen && actLedAmber))
        else $error("green and amber together");
    a_trunk_lane: assert property (upCnt > 1 |-> trunkTxData == expTx)
        else $error("trunk byte from wrong lane");
    c_fallback: cover property (txClockSel);
    c_error: cover property (pslverr);
    c_standby: cover property (actLedAmber);
    c_sigfail: cover property (signalFailLed);
endmodule

bind mxp_status_timing mxp_status_timing_sva mxp_status_timing_sva_inst (
    .sys_clk, .resetn, .psel, .penable, .prdata, .pready, .pslverr,
    .clientTxData, .trunkTxData, .shelfClkAOk, .shelfClkBOk, .txClockSel,
    .clockAlarm, .lossOfSignal, .lossOfFrame, .highBer, .fiberMiswire,
    .actLedGreen, .actLedAmber, .signalFailLed, .wave1Led, .wave2Led
);

//--- bench/far_end_model.sv
`timescale 1ns/1ps
// ==========================================
// far side: client traffic source and trunk loop fibre
module far_end_model (
    input wire sys_clk,
    input wire resetn,
    input wire [7:0] trunkTxData,
    input wire trunkLaserOn,
    output reg [31:0] clientTxData,
    output reg [7:0] trunkRxData
);
    // low two bits of every byte name its lane until byte 0 first carries, 64 cycles after reset, so the demux can be traced
    always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            clientTxData <= 32'h03020100;
            trunkRxData <= 8'h00;
        end else begin
            clientTxData <= clientTxData + 32'h04040404;
            // dark fibre carries no stable byte, so flip the last one
            if (trunkLaserOn) begin
                trunkRxData <= trunkTxData;
            end else begin
                trunkRxData <= ~trunkRxData;
            end
        end
    end
endmodule

//--- bench/tb_mxp_status_timing.sv
`timescale 1ns/1ps
`include "mxp_defs.vh"
// ==========================================
// bench for the status and timing block
module tb_mxp_status_timing;
    reg sys_clk = 1'b0;
    reg resetn = 1'b0;
    reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg shelfClkAOk = 1'b1, shelfClkBOk = 1'b1, fiberMiswire = 1'b0;
    reg [4:0] lossOfSignal = 5'h00, lossOfFrame = 5'h00, highBer = 5'h00;
    wire [31:0] prdata, clientTxData, clientRxData;
    wire [7:0] trunkTxData, trunkRxData;
    wire [3:0] clientLaserOn, clientLed;
    wire pready, pslverr, irq, trunkRateSel, txClockSel, clockAlarm, trunkLaserOn;
    wire failLed, actLedGreen, actLedAmber, signalFailLed, trunkLed, wave1Led, wave2Led;
    reg lastErr; // error flag of the latest transfer
    int n_fail = 0;
    int compares = 0;
    always #5 sys_clk = ~sys_clk;
    // ten cycles stand for one second to keep the run short
    mxp_status_timing #(.SEC_CYCLES(10)) mxp_status_timing_inst (.sys_clk, .resetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq,
        .clientTxData, .trunkTxData, .trunkRxData, .clientRxData, .trunkRateSel,
        .shelfClkAOk, .shelfClkBOk, .txClockSel, .clockAlarm, .lossOfSignal,
        .lossOfFrame, .highBer, .fiberMiswire, .clientLaserOn, .trunkLaserOn, .failLed,
        .actLedGreen, .actLedAmber, .signalFailLed, .clientLed, .trunkLed, .wave1Led,
        .wave2Led);
    far_end_model far_end_model_inst (.sys_clk, .resetn, .trunkTxData, .trunkLaserOn,
        .clientTxData, .trunkRxData);
    // ==========================================
    // shared tasks
    task automatic wrap_up;
        if (n_fail == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // one apb transfer; request held until ready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int k;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge sys_clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        q = prdata;
        lastErr = pslverr;
        if (k >= 20) begin
            check(32'h0, 32'h1);
            wrap_up();
        end
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask
    // ==========================================
    // scenarios
    task automatic t_regs;
        logic [31:0] q;
        rd_chk(`OFF_CTRL, 32'h0);
        rd_chk(`OFF_IRQ_MASK, 32'h0);
        rd_chk(`OFF_ALS_ON, 32'h3d);
        rd_chk(`OFF_ALS_OFF, 32'h3d);
        rd_chk(8'h20, 32'h0);
        check(32'(lastErr), 32'h1);
        wr(`OFF_CTRL, 32'h1);
        tick(1);
        check(32'(trunkRateSel), 32'h1);
        wr(`OFF_CTRL, 32'h0);
        tick(1);
        check(32'(trunkRateSel), 32'h0);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] q;
        apb(1'b0, a, 32'h0, q);
        check(q, e);
    endtask
    // lane tags must rotate consistently through the loop fibre
    task automatic t_stream;
        tick(10);
        for (int i = 1; i < 4; i++) begin
            check(32'(2'(clientRxData[8*i +: 2] - 2'(i))), 32'(clientRxData[1:0]));
        end
    endtask
    task automatic t_fallback;
        wr(`OFF_IRQ_MASK, 32'h1);
        shelfClkAOk <= 1'b0;
        tick(5);
        check(32'(txClockSel), 32'h0);
        shelfClkBOk <= 1'b0;
        tick(5);
        check({txClockSel, clockAlarm, irq}, 32'h7);
        shelfClkAOk <= 1'b1;
        tick(5);
        check({txClockSel, irq}, 32'h1);
        wr(`OFF_IRQ_STAT, 32'h1);
        tick(2);
        check(32'(irq), 32'h0);
        wr(`OFF_IRQ_MASK, 32'h0);
        shelfClkAOk <= 1'b0;
        tick(5);
        check(32'(irq), 32'h0);
        rd_chk(`OFF_IRQ_STAT, 32'h1);
        shelfClkAOk <= 1'b1;
        shelfClkBOk <= 1'b1;
        wr(`OFF_IRQ_STAT, 32'h1);
    endtask
    task automatic t_sigfail;
        for (int i = 0; i < 16; i++) begin
            lossOfSignal <= (i < 5) ? 5'h01 << i : 5'h00;
            lossOfFrame <= (i >= 5 && i < 10) ? 5'h01 << (i - 5) : 5'h00;
            highBer <= (i >= 10 && i < 15) ? 5'h01 << (i - 10) : 5'h00;
            fiberMiswire <= (i == 15);
            tick(5);
            check(32'(signalFailLed), 32'h1);
            {lossOfSignal, lossOfFrame, highBer, fiberMiswire} <= 16'h0;
            tick(5);
            check(32'(signalFailLed), 32'h0);
        end
    endtask
    task automatic t_leds;
        int c;
        logic p;
        wr(`OFF_CTRL, 32'h3e4);
        tick(3);
        check({failLed, actLedGreen, actLedAmber, trunkLed}, 32'h5);
        check({clientLed, wave1Led, wave2Led}, 32'h3e);
        lossOfSignal <= 5'h04;
        lossOfFrame <= 5'h10;
        tick(5);
        check({clientLed, trunkLed}, 32'h16);
        {lossOfSignal, lossOfFrame} <= 10'h0;
        wr(`OFF_CTRL, 32'h3f6);
        tick(3);
        check({actLedGreen, actLedAmber, wave1Led, wave2Led}, 32'h5);
        wr(`OFF_CTRL, 32'h3ec);
        // let the led leave its steady level before counting flashes
        tick(2);
        p = failLed;
        c = 0;
        repeat (45) begin
            tick(1);
            if (failLed !== p) c++;
            p = failLed;
        end
        check(32'(c >= 4 && c <= 5), 32'h1);
        wr(`OFF_CTRL, 32'h0);
        tick(3);
        check(32'(failLed), 32'h1);
    endtask
    // off phase programmed to 62 s, on phase asked 5 s and held to 61 s
    task automatic t_als;
        int n;
        wr(`OFF_ALS_OFF, 32'h3e);
        wr(`OFF_ALS_ON, 32'h5);
        wr(`OFF_CTRL, 32'h400);
        lossOfSignal <= 5'h12;
        tick(5);
        check({trunkLaserOn, clientLaserOn}, 32'hd);
        rd_chk(`OFF_STATUS, 32'h00120012);
        for (n = 0; !trunkLaserOn && n < 2000; n++) tick(1);
        check(32'(n >= 600 && n <= 630), 32'h1);
        for (n = 0; trunkLaserOn && n < 2000; n++) tick(1);
        check(32'(n >= 595 && n <= 625), 32'h1);
        rd_chk(`OFF_IRQ_STAT, 32'h6);
        lossOfSignal <= 5'h00;
        wr(`OFF_CTRL, 32'h0);
        tick(5);
        check({trunkLaserOn, clientLaserOn}, 32'h1f);
    endtask
    // ==========================================
    // main sequence
    initial begin
        tick(12);
        check({failLed, trunkLaserOn, clientLaserOn}, 32'h3f);
        resetn <= 1'b1;
        tick(1);
        t_regs();
        t_stream();
        t_fallback();
        t_sigfail();
        t_leds();
        t_als();
        wrap_up();
    end
endmodule
